// file: rtl/exrg_pkg.sv
// Purpose: shared constants and types for the exception and region attribute block
// Assumes: 32-bit address map, nine peripheral interrupts
// Notes:   exception numbers and vector addresses are fixed by the map
package exrg_pkg;

    localparam int unsigned NUM_IRQ      = 9;
    localparam int unsigned NUM_EXC      = 25;
    localparam int unsigned EXC_W        = 5;

    // exception numbers
    localparam logic [4:0] EXC_NONE      = 5'h00;
    localparam logic [4:0] EXC_RESET     = 5'h01;
    localparam logic [4:0] EXC_NMI       = 5'h02;
    localparam logic [4:0] EXC_FAULT     = 5'h03;
    localparam logic [4:0] EXC_SVC       = 5'h0B;
    localparam logic [4:0] EXC_PENDSRV   = 5'h0E;
    localparam logic [4:0] EXC_TICK      = 5'h0F;
    localparam logic [4:0] EXC_IRQ_BASE  = 5'h10;

    // vector table entries and step
    localparam logic [31:0] VEC_RESET    = 32'h0000_0004;
    localparam logic [31:0] VEC_SVC      = 32'h0000_002C;
    localparam logic [31:0] VEC_PENDSRV  = 32'h0000_0038;
    localparam logic [31:0] VEC_TICK     = 32'h0000_003C;
    localparam logic [31:0] VEC_IRQ_BASE = 32'h0000_0040;
    localparam logic [31:0] VEC_STEP     = 32'h0000_0004;

    // region boundaries
    localparam logic [31:0] RAM_BASE     = 32'h2000_0000;
    localparam logic [31:0] PERI_BASE    = 32'h4000_0000;
    localparam logic [31:0] XRAM_BASE    = 32'h6000_0000;
    localparam logic [31:0] XRAM_TOP     = 32'h9FFF_FFFF;
    localparam logic [31:0] XDEV_BASE    = 32'hA000_0000;
    localparam logic [31:0] PRIV_BASE    = 32'hE000_0000;
    localparam logic [31:0] PRIV_TOP     = 32'hE00F_FFFF;
    localparam logic [31:0] VEND_BASE    = 32'hE010_0000;

    // priorities: smaller is more urgent; fixed levels sit below all configurable
    localparam logic [3:0]  PRI_RESET    = 4'h0;
    localparam logic [3:0]  PRI_NMI      = 4'h1;
    localparam logic [3:0]  PRI_FAULT    = 4'h2;
    localparam logic [3:0]  PRI_CFG_OFS  = 4'h4;
    localparam logic [3:0]  PRI_IDLE     = 4'hF;
    localparam logic [1:0]  CFG_PRI_RST  = 2'h0;

    // access sizes
    localparam logic [1:0]  SIZE_BYTE    = 2'h0;
    localparam logic [1:0]  SIZE_HALF    = 2'h1;
    localparam logic [1:0]  SIZE_WORD    = 2'h2;

    typedef enum logic [1:0] {
        EXRG_MEM_NORMAL,
        EXRG_MEM_DEVICE,
        EXRG_MEM_STRONG
    } exrg_memtype_t;

endpackage : exrg_pkg

// file: rtl/exrg_region_dec.sv
// Purpose: decode an address into memory type, execute-never and word-only attributes
// Assumes: fixed address map
// Notes:   purely combinational; caller registers the result
`timescale 1ns/1ps
module exrg_region_dec (
    input  wire logic [31:0]            addr,
    output exrg_pkg::exrg_memtype_t     mem_type,
    output logic                        execute_never,
    output logic                        word_only
);
    always_comb begin
        mem_type      = exrg_pkg::EXRG_MEM_NORMAL;
        execute_never = 1'b0;
        word_only     = 1'b0;
        if (addr < exrg_pkg::PERI_BASE) begin
            mem_type = exrg_pkg::EXRG_MEM_NORMAL;
        end else if (addr < exrg_pkg::XRAM_BASE) begin
            mem_type      = exrg_pkg::EXRG_MEM_DEVICE;
            execute_never = 1'b1;
        end else if (addr <= exrg_pkg::XRAM_TOP) begin
            mem_type = exrg_pkg::EXRG_MEM_NORMAL;
        end else if (addr < exrg_pkg::PRIV_BASE) begin
            mem_type      = exrg_pkg::EXRG_MEM_DEVICE;
            execute_never = 1'b1;
        end else if (addr <= exrg_pkg::PRIV_TOP) begin
            mem_type      = exrg_pkg::EXRG_MEM_STRONG;
            execute_never = 1'b1;
            word_only     = 1'b1;
        end else begin
            mem_type      = exrg_pkg::EXRG_MEM_DEVICE;
            execute_never = 1'b1;
        end
    end
endmodule // exrg_region_dec

// file: rtl/exrg_byte_lane.sv
// Purpose: place store data on little-endian byte lanes
// Assumes: aligned accesses
// Notes:   combinational
`timescale 1ns/1ps
module exrg_byte_lane (
    input  wire logic [1:0]  addr_lo,
    input  wire logic [1:0]  size,
    input  wire logic [31:0] wdata_in,
    output logic      [31:0] wdata_lane,
    output logic      [3:0]  byte_en
);
    always_comb begin
        wdata_lane = wdata_in;
        byte_en    = 4'hF;
        case (size)
            exrg_pkg::SIZE_BYTE: begin
                // lsbyte lands at the addressed byte lane
                wdata_lane = {4{wdata_in[7:0]}};
                byte_en    = 4'h1 << addr_lo;
            end
            exrg_pkg::SIZE_HALF: begin
                wdata_lane = {2{wdata_in[15:0]}};
                byte_en    = addr_lo[1] ? 4'hC : 4'h3;
            end
            default: begin
                wdata_lane = wdata_in;
                byte_en    = 4'hF;
            end
        endcase
    end
endmodule // exrg_byte_lane

// file: rtl/exrg_core.sv
// Purpose: exception state tracking, priority ranking, vectoring, region checks, barriers
// Assumes: single clock, synchronous reset; requests come from logic on sys_clk
// Notes:   one exception taken per cycle; handlers end with exc_return
`timescale 1ns/1ps
module exrg_core #(
    parameter int unsigned N_IRQ = exrg_pkg::NUM_IRQ
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire logic [N_IRQ-1:0]        irq_req,
    input  wire logic [N_IRQ-1:0]        irq_enable,
    input  wire logic [2*N_IRQ-1:0]      irq_pri,
    input  wire logic                    nmi_req,
    input  wire logic                    svc_exec,
    input  wire logic                    pendsrv_req,
    input  wire logic                    pendsrv_enable,
    input  wire logic [1:0]              pendsrv_pri,
    input  wire logic                    svc_enable,
    input  wire logic [1:0]              svc_pri,
    input  wire logic                    tick_zero,
    input  wire logic                    tick_sw_req,
    input  wire logic                    tick_enable,
    input  wire logic [1:0]              tick_pri,
    input  wire logic                    proc_error,
    input  wire logic                    fetch_valid,
    input  wire logic [31:0]             fetch_addr,
    input  wire logic                    exc_return,
    input  wire logic                    mem_req,
    input  wire logic [31:0]             mem_addr,
    input  wire logic [1:0]              mem_size,
    input  wire logic [31:0]             mem_wdata,
    input  wire logic                    mem_done,
    input  wire logic                    barrier_dmb,
    input  wire logic                    barrier_dsb,
    input  wire logic                    barrier_isb,
    output logic                         exc_take_q,
    output logic [4:0]                   exc_num_q,
    output logic [31:0]                  exc_vector_q,
    output logic                         thread_mode_q,
    output logic [4:0]                   cur_exc_q,
    output logic [31:0]                  pending_q,
    output logic [31:0]                  active_q,
    output logic                         mem_go_q,
    output logic                         mem_size_err_q,
    output exrg_pkg::exrg_memtype_t      mem_type_q,
    output logic [31:0]                  mem_wlane_q,
    output logic [3:0]                   mem_ben_q,
    output logic                         exec_stall_q,
    output logic                         flush_q
);
    initial begin
        if (N_IRQ < 1 || N_IRQ > 16) $error("exrg_core: N_IRQ must be 1..16");
    end

    // vector address for an exception number
    function automatic logic [31:0] vec_of(input logic [4:0] n);
        vec_of = {25'h000_0000, n, 2'b00};
    endfunction

    // rank of an exception; lower is more urgent
    function automatic logic [3:0] cfg_rank(input logic [1:0] p);
        cfg_rank = exrg_pkg::PRI_CFG_OFS + {2'b00, p};
    endfunction

    // region attributes
    exrg_pkg::exrg_memtype_t fetch_type;
    logic                    fetch_xn;
    logic                    fetch_wo;
    exrg_pkg::exrg_memtype_t data_type;
    logic                    data_xn;
    logic                    data_wo;
    logic [31:0]             wlane;
    logic [3:0]              ben;

    exrg_region_dec u_fetch_dec (
        .addr          (fetch_addr),
        .mem_type      (fetch_type),
        .execute_never (fetch_xn),
        .word_only     (fetch_wo)
    );

    exrg_region_dec u_data_dec (
        .addr          (mem_addr),
        .mem_type      (data_type),
        .execute_never (data_xn),
        .word_only     (data_wo)
    );

    exrg_byte_lane u_lane (
        .addr_lo    (mem_addr[1:0]),
        .size       (mem_size),
        .wdata_in   (mem_wdata),
        .wdata_lane (wlane),
        .byte_en    (ben)
    );

    // requests raised this cycle, one bit per exception number
    logic [31:0] raise;
    logic [31:0] enabled;
    logic        xn_fault;
    assign xn_fault = fetch_valid & fetch_xn;

    always_comb begin
        raise = 32'h0000_0000;
        raise[exrg_pkg::EXC_NMI]     = nmi_req;
        raise[exrg_pkg::EXC_FAULT]   = proc_error | xn_fault;
        raise[exrg_pkg::EXC_SVC]     = svc_exec;
        raise[exrg_pkg::EXC_PENDSRV] = pendsrv_req;
        raise[exrg_pkg::EXC_TICK]    = tick_zero | tick_sw_req;
        for (int i = 0; i < N_IRQ; i++) begin
            raise[exrg_pkg::EXC_IRQ_BASE + 5'(i)] = irq_req[i];
        end
    end

    always_comb begin
        enabled = 32'h0000_0000;
        // fixed exceptions cannot be disabled
        enabled[exrg_pkg::EXC_NMI]     = 1'b1;
        enabled[exrg_pkg::EXC_FAULT]   = 1'b1;
        enabled[exrg_pkg::EXC_SVC]     = svc_enable;
        enabled[exrg_pkg::EXC_PENDSRV] = pendsrv_enable;
        enabled[exrg_pkg::EXC_TICK]    = tick_enable;
        for (int i = 0; i < N_IRQ; i++) begin
            enabled[exrg_pkg::EXC_IRQ_BASE + 5'(i)] = irq_enable[i];
        end
    end

    function automatic logic [3:0] rank_of(input logic [4:0] n);
        logic [4:0] k;
        k = n - exrg_pkg::EXC_IRQ_BASE;
        case (n)
            exrg_pkg::EXC_NONE:    rank_of = exrg_pkg::PRI_IDLE;
            exrg_pkg::EXC_NMI:     rank_of = exrg_pkg::PRI_NMI;
            exrg_pkg::EXC_FAULT:   rank_of = exrg_pkg::PRI_FAULT;
            exrg_pkg::EXC_SVC:     rank_of = cfg_rank(svc_pri);
            exrg_pkg::EXC_PENDSRV: rank_of = cfg_rank(pendsrv_pri);
            exrg_pkg::EXC_TICK:    rank_of = cfg_rank(tick_pri);
            default: begin
                if (n >= exrg_pkg::EXC_IRQ_BASE && k < 5'(N_IRQ)) begin
                    rank_of = cfg_rank(irq_pri[2*k +: 2]);
                end else begin
                    rank_of = exrg_pkg::PRI_IDLE;
                end
            end
        endcase
    endfunction

    // pick most urgent enabled pending; lowest number wins ties
    logic [4:0] best_num;
    logic [3:0] best_rank;
    always_comb begin
        best_num  = exrg_pkg::EXC_NONE;
        best_rank = exrg_pkg::PRI_IDLE;
        for (int n = 31; n >= 1; n--) begin
            if (pending_q[n] && enabled[n] && !active_q[n] && rank_of(5'(n)) <= best_rank) begin
                best_num  = 5'(n);
                best_rank = rank_of(5'(n));
            end
        end
    end

    // preempt only when strictly more urgent than the running handler
    logic take;
    assign take = (best_num != exrg_pkg::EXC_NONE) && (best_rank < rank_of(cur_exc_q))
                  && !exec_stall_q;

    // nesting stack of preempted handlers
    logic [4:0] stack_q [0:7];
    logic [2:0] depth_q;

    // pending bits: set wins over the clear done on entry
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pending_q <= 32'h0000_0000;
        end else begin
            for (int n = 0; n < 32; n++) begin
                if (raise[n]) begin
                    pending_q[n] <= 1'b1;
                end else if (take && best_num == 5'(n)) begin
                    pending_q[n] <= 1'b0;
                end
            end
        end
    end

    // active bits: preempted handlers stay active
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            active_q <= 32'h0000_0000;
        end else if (take) begin
            active_q[best_num] <= 1'b1;
        end else if (exc_return && cur_exc_q != exrg_pkg::EXC_NONE) begin
            active_q[cur_exc_q] <= 1'b0;
        end
    end

    // current exception and thread mode; reset restarts in thread mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur_exc_q     <= exrg_pkg::EXC_NONE;
            thread_mode_q <= 1'b1;
            depth_q       <= 3'h0;
            for (int i = 0; i < 8; i++) stack_q[i] <= exrg_pkg::EXC_NONE;
        end else if (take) begin
            stack_q[depth_q] <= cur_exc_q;
            depth_q          <= depth_q + 3'h1;
            cur_exc_q        <= best_num;
            thread_mode_q    <= 1'b0;
        end else if (exc_return && depth_q != 3'h0) begin
            cur_exc_q     <= stack_q[depth_q - 3'h1];
            depth_q       <= depth_q - 3'h1;
            thread_mode_q <= (stack_q[depth_q - 3'h1] == exrg_pkg::EXC_NONE);
        end
    end

    // entry announcement; first cycle after reset fetches the reset vector
    logic boot_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boot_q       <= 1'b1;
            exc_take_q   <= 1'b0;
            exc_num_q    <= exrg_pkg::EXC_NONE;
            exc_vector_q <= 32'h0000_0000;
        end else if (boot_q) begin
            boot_q       <= 1'b0;
            exc_take_q   <= 1'b1;
            exc_num_q    <= exrg_pkg::EXC_RESET;
            exc_vector_q <= exrg_pkg::VEC_RESET;
        end else begin
            exc_take_q   <= take;
            exc_num_q    <= take ? best_num : exrg_pkg::EXC_NONE;
            exc_vector_q <= take ? vec_of(best_num) : 32'h0000_0000;
        end
    end

    // outstanding transaction count for barriers
    logic [3:0] outst_q;
    logic       bad_size;
    logic       so_block;
    logic       issue;
    assign bad_size = data_wo && (mem_size != exrg_pkg::SIZE_WORD);
    // strongly-ordered accesses wait for prior ones; normal ones may overlap
    assign so_block = (data_type == exrg_pkg::EXRG_MEM_STRONG) && (outst_q != 4'h0);
    assign issue    = mem_req && !bad_size && !so_block && !exec_stall_q && outst_q != 4'hF;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            outst_q <= 4'h0;
        end else begin
            outst_q <= outst_q + 4'(issue) - 4'(mem_done && outst_q != 4'h0);
        end
    end

    // barrier: hold transactions and execution until drained
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            exec_stall_q <= 1'b0;
        end else if (barrier_dmb || barrier_dsb) begin
            exec_stall_q <= 1'b1;
        end else if (outst_q == 4'h0 || (outst_q == 4'h1 && mem_done)) begin
            exec_stall_q <= 1'b0;
        end
    end

    // fetch pipe refill after an instruction barrier
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= barrier_isb && !exec_stall_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_go_q       <= 1'b0;
            mem_size_err_q <= 1'b0;
            mem_type_q     <= exrg_pkg::EXRG_MEM_NORMAL;
            mem_wlane_q    <= 32'h0000_0000;
            mem_ben_q      <= 4'h0;
        end else begin
            mem_go_q       <= issue;
            mem_size_err_q <= mem_req && bad_size;
            mem_type_q     <= data_type;
            mem_wlane_q    <= wlane;
            mem_ben_q      <= issue ? ben : 4'h0;
        end
    end

    property p_xn_fault;
        @(posedge sys_clk) disable iff (reset)
        (fetch_valid && fetch_xn) |=> pending_q[exrg_pkg::EXC_FAULT];
    endproperty
    a_xn_fault: assert property (p_xn_fault) else $error("no fault on no-execute fetch");

    property p_word_only;
        @(posedge sys_clk) disable iff (reset)
        (mem_req && data_wo && mem_size != exrg_pkg::SIZE_WORD) |=> (mem_size_err_q && !mem_go_q);
    endproperty
    a_word_only: assert property (p_word_only) else $error("sub-word access to private region");

    property p_pending_set;
        @(posedge sys_clk) disable iff (reset)
        irq_req[0] |=> pending_q[exrg_pkg::EXC_IRQ_BASE] || active_q[exrg_pkg::EXC_IRQ_BASE];
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("request not pended");

    property p_nested;
        @(posedge sys_clk) disable iff (reset)
        (take && cur_exc_q != exrg_pkg::EXC_NONE) |=> active_q[$past(cur_exc_q)];
    endproperty
    a_nested: assert property (p_nested) else $error("preempted handler lost active");

    property p_reset_vec;
        @(posedge sys_clk) $fell(reset) |-> ##1 (exc_vector_q == exrg_pkg::VEC_RESET && thread_mode_q);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("bad restart after reset");

    property p_nmi_not_preempted;
        @(posedge sys_clk) disable iff (reset)
        (cur_exc_q == exrg_pkg::EXC_NMI) |-> !take;
    endproperty
    a_nmi_not_preempted: assert property (p_nmi_not_preempted) else $error("nmi preempted");

    property p_svc_vector;
        @(posedge sys_clk) disable iff (reset)
        (exc_take_q && exc_num_q == exrg_pkg::EXC_SVC) |-> exc_vector_q == exrg_pkg::VEC_SVC;
    endproperty
    a_svc_vector: assert property (p_svc_vector) else $error("wrong supervisor call vector");

    property p_pendsrv_vector;
        @(posedge sys_clk) disable iff (reset)
        (exc_take_q && exc_num_q == exrg_pkg::EXC_PENDSRV) |-> exc_vector_q == exrg_pkg::VEC_PENDSRV;
    endproperty
    a_pendsrv_vector: assert property (p_pendsrv_vector) else $error("wrong service vector");

    property p_tick_vector;
        @(posedge sys_clk) disable iff (reset)
        (exc_take_q && exc_num_q == exrg_pkg::EXC_TICK) |-> exc_vector_q == exrg_pkg::VEC_TICK;
    endproperty
    a_tick_vector: assert property (p_tick_vector) else $error("wrong tick vector");

    property p_barrier_hold;
        @(posedge sys_clk) disable iff (reset)
        (exec_stall_q && outst_q != 4'h0) |-> ##1 !mem_go_q;
    endproperty
    a_barrier_hold: assert property (p_barrier_hold) else $error("access passed barrier");

    c_nest: cover property (@(posedge sys_clk) disable iff (reset) take && depth_q == 3'h1);
    c_fault: cover property (@(posedge sys_clk) disable iff (reset) exc_num_q == exrg_pkg::EXC_FAULT);
    c_barrier: cover property (@(posedge sys_clk) disable iff (reset) $fell(exec_stall_q));

endmodule // exrg_core

// file: verif/exrg_mem_model.sv
// Purpose: far-side memory that completes every issued access
// Assumes: one completion per issue, fixed latency of three cycles
// Notes:   fixed latency keeps strong-region waits predictable
`timescale 1ns/1ps
module exrg_mem_model (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic mem_go_q,
    output logic      mem_done
);
    logic [2:0] lat_q;
    always_ff @(posedge sys_clk) begin
        lat_q <= reset ? 3'h0 : {lat_q[1:0], mem_go_q};
    end
    assign mem_done = lat_q[2];
endmodule // exrg_mem_model

// file: verif/exception_and_region_attribute_logic_tb.sv
// Purpose: self-checking bench for exrg_core
// Assumes: memory model answers three cycles after issue
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module exception_and_region_attribute_logic_tb;
    logic sys_clk, reset, mem_req, fetch_valid, mem_done;
    logic exc_take_q, thread_mode_q, mem_go_q, mem_size_err_q, flush_q;
    logic [6:0] ev;
    logic [2:0] bar, en;
    logic [8:0] irq_req, irq_enable;
    logic [1:0] mem_size;
    logic [4:0] exc_num_q;
    logic [3:0] mem_ben_q;
    logic [31:0] fetch_addr, mem_addr, mem_wdata, exc_vector_q, pending_q, active_q, mem_wlane_q;
    exrg_pkg::exrg_memtype_t mem_type_q;
    int fails = 0;
    int tests_run = 0;
    exrg_core dut (.sys_clk, .reset, .irq_req, .irq_enable, .irq_pri(18'h3_FFFF),
        .nmi_req(ev[0]), .svc_exec(ev[1]), .pendsrv_req(ev[2]), .tick_sw_req(ev[3]),
        .proc_error(ev[4]), .exc_return(ev[5]), .tick_zero(ev[6]), .svc_enable(en[0]),
        .pendsrv_enable(en[1]), .tick_enable(en[2]), .svc_pri(2'h3), .pendsrv_pri(2'h3),
        .tick_pri(2'h3), .fetch_valid, .fetch_addr, .mem_req, .mem_addr, .mem_size,
        .mem_wdata, .mem_done, .barrier_dmb(bar[0]), .barrier_dsb(bar[1]), .barrier_isb(bar[2]),
        .exc_take_q, .exc_num_q, .exc_vector_q, .thread_mode_q, .cur_exc_q(), .pending_q,
        .active_q, .mem_go_q, .mem_size_err_q, .mem_type_q, .mem_wlane_q, .mem_ben_q,
        .exec_stall_q(), .flush_q);
    exrg_mem_model mem (.sys_clk, .reset, .mem_go_q, .mem_done);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic pulse(input int b);
        @(negedge sys_clk) ev[b] = 1'b1;
        @(negedge sys_clk) ev[b] = 1'b0;
    endtask
    task automatic pirq(input int i);
        @(negedge sys_clk) irq_req[i] = 1'b1;
        @(negedge sys_clk) irq_req[i] = 1'b0;
    endtask
    // bounded wait for the next take, then check number, vector and active bit
    task automatic take(input logic [4:0] n, input logic [31:0] v);
        int i;
        for (i = 0; i < 20 && exc_take_q !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 20) begin
            fails++;
            tally_and_finish();
        end
        chk({27'h0, exc_num_q}, {27'h0, n});
        chk(exc_vector_q, v);
        chk({31'h0, active_q[n]}, 32'h0000_0001);
        // word-aligned slot address; bit 0 of the entry itself belongs to software
        chk({30'h0, exc_vector_q[1:0]}, 32'h0000_0000);
    endtask
    // barrier with one access in flight: the next access waits until the first completes
    task automatic t_bar();
        for (int b = 0; b < 2; b++) begin
            repeat (6) @(negedge sys_clk);
            {mem_req, mem_addr, mem_size} = {1'b1, 32'h2000_0000, 2'h2};
            bar[b] = 1'b1;
            for (int k = 1; k < 7; k++) begin
                @(negedge sys_clk) bar[b] = 1'b0;
                chk({31'h0, mem_go_q}, {31'h0, k == 1 || k == 6});
            end
            mem_req = 1'b0;
        end
        $display("test barriers done");
    endtask
    task automatic t_sys();
        int b [6] = '{1, 2, 3, 6, 0, 4};
        logic [4:0] n [6] = '{5'h0B, 5'h0E, 5'h0F, 5'h0F, 5'h02, 5'h03};
        logic [7:0] v [6] = '{8'h2C, 8'h38, 8'h3C, 8'h3C, 8'h08, 8'h0C};
        for (int k = 0; k < 6; k++) begin
            pulse(b[k]);
            take(n[k], {24'h0, v[k]});
            pulse(5);
        end
        $display("test system exceptions done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < 9; i += 8) begin
            pirq(i);
            take(5'(16 + i), 32'h0000_0040 + 32'(4 * i));
            pulse(5);
        end
        pirq(0);
        take(5'h10, 32'h0000_0040);
        pirq(0);
        pulse(0);
        take(5'h02, 32'h0000_0008);
        chk({29'h0, active_q[16], active_q[2], pending_q[16]}, 32'h0000_0007);
        pulse(5);
        pulse(5);
        take(5'h10, 32'h0000_0040);
        pulse(5);
        @(negedge sys_clk) irq_enable[1] = 1'b0;
        pirq(1);
        repeat (4) @(negedge sys_clk);
        chk({30'h0, exc_take_q, pending_q[17]}, 32'h0000_0001);
        irq_enable[1] = 1'b1;
        take(5'h11, 32'h0000_0044);
        pulse(5);
        $display("test interrupts done");
    endtask
    task automatic t_mem();
        logic [31:0] a [8] = '{32'h2000_0000, 32'h2000_0001, 32'h6000_0002, 32'h4000_0000,
            32'hE000_0004, 32'hE000_0000, 32'hE00F_FFFC, 32'hE010_0000};
        logic [1:0] s [8] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
        logic [7:0] e [8] = '{8'hBC, 8'h88, 8'hB0, 8'hBD, 8'hBE, 8'h40, 8'h40, 8'h85};
        for (int k = 0; k < 8; k++) begin
            repeat (4) @(negedge sys_clk);
            mem_req = 1'b1;
            mem_addr = a[k];
            mem_size = s[k];
            @(negedge sys_clk);
            chk({24'h0, mem_go_q, mem_size_err_q, mem_ben_q, mem_go_q ? 2'(mem_type_q) : 2'h0},
                {24'h0, e[k]});
            if (k < 2) chk(mem_wlane_q, k == 0 ? 32'h1122_3344 : 32'h4444_4444);
            mem_req = 1'b0;
        end
        $display("test memory regions done");
    endtask
    task automatic t_fetch();
        @(negedge sys_clk) fetch_valid = 1'b1;
        fetch_addr = 32'h9FFF_FFFC;
        @(negedge sys_clk) fetch_addr = 32'hE000_0000;
        chk({31'h0, pending_q[3]}, 32'h0000_0000);
        @(negedge sys_clk) fetch_valid = 1'b0;
        take(5'h03, 32'h0000_000C);
        pulse(5);
        @(negedge sys_clk) bar[2] = 1'b1;
        @(negedge sys_clk) chk({31'h0, flush_q}, 32'h0000_0001);
        bar[2] = 1'b0;
        @(negedge sys_clk) chk({31'h0, flush_q}, 32'h0000_0000);
        $display("test fetch and barrier done");
    endtask
    initial begin
        {reset, mem_req, fetch_valid, ev, bar, irq_req, mem_size} = '1;
        {mem_req, fetch_valid, ev, bar, irq_req, mem_size} = '0;
        en = 3'h7;
        irq_enable = 9'h1FF;
        fetch_addr = 32'h0000_0000;
        mem_addr = 32'h0000_0000;
        mem_wdata = 32'h1122_3344;
        repeat (16) @(posedge sys_clk);
        #1 chk({31'h0, thread_mode_q}, 32'h0000_0001);
        @(negedge sys_clk) reset = 1'b0;
        @(posedge sys_clk);
        #1 chk({26'h0, exc_take_q, exc_num_q}, 32'h0000_0021);
        chk(exc_vector_q, 32'h0000_0004);
        $display("test reset done");
        t_sys();
        t_irq();
        t_mem();
        t_bar();
        t_fetch();
        tally_and_finish();
    end
endmodule // exception_and_region_attribute_logic_tb
